// ### logic/ewb_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite word per register, byte addresses below
// Notes: Narrow registers sit in the low bits; upper bits read as zero
`ifndef EWB_REGS_VH
`define EWB_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EWB_OFS_PERIOD 5'h00
`define EWB_OFS_DUTY 5'h04
`define EWB_OFS_CCCTL 5'h08
`define EWB_OFS_RSTDLY 5'h0C
`define EWB_OFS_TMRCTL 5'h10
`define EWB_OFS_STEER 5'h14
`define EWB_OFS_STATUS 5'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EWB_CC_DLSB 4
`define EWB_CC_MLSB 6
`define EWB_RD_RSEN 7
`define EWB_TC_RUN 2
`define EWB_ST_SES 0
`define EWB_ST_PIN 1
`define EWB_ST_CNT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EWB_RST_PERIOD 8'hFF
`define EWB_RST_DUTY 8'h00
`define EWB_RST_CCCTL 8'h00
`define EWB_RST_RSTDLY 8'h00
`define EWB_RST_TMRCTL 3'h0
`define EWB_RST_STEER 4'h1

// ----------------------------------------
// Modes and timing
// ----------------------------------------
`define EWB_MODE_SINGLE 2'h0
`define EWB_MODE_FWD 2'h1
`define EWB_MODE_HALF 2'h2
`define EWB_MODE_REV 2'h3
`define EWB_OSC_PERIOD_NS 100
`define EWB_INSTR_NS 400
`define EWB_INSTR_CYC (`EWB_INSTR_NS / `EWB_OSC_PERIOD_NS)
`define EWB_RESP_OKAY 2'h0
`define EWB_RESP_SLVERR 2'h2

`endif

// ### logic/ewb_timebase.v
// Purpose: Prescaled timebase with quarter-step fine count
// Assumes: One clock_in period is one oscillator period
// Notes: Fine count is {timebase_counter, two sub-step bits}
`timescale 1ns/1ns
module ewb_timebase (
  input wire clock_in, // Oscillator clock
  input wire reset_in, // Async reset, active high
  input wire run_in, // Timebase runs
  input wire [1:0] prescale_sel_in, // 0: 1, 1: 4, else 16
  input wire [7:0] period_limit_in, // Period limit
  output reg [9:0] fine_q, // Fine count
  output reg period_start_q // Pulse at wrap
);
  reg [3:0] pre_q;
  reg [3:0] pre_top;
  wire tick;

  // Prescale terminal value
  always @* begin
    case (prescale_sel_in)
      2'h0: pre_top = 4'h0;
      2'h1: pre_top = 4'h3;
      default: pre_top = 4'hF;
    endcase
  end
  assign tick = run_in && (pre_q >= pre_top);

  // Each fine step lasts one oscillator period times the prescale
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pre_q <= 4'h0;
      fine_q <= 10'h000;
      period_start_q <= 1'b0;
    end else begin
      period_start_q <= 1'b0;
      if (!run_in) begin
        pre_q <= 4'h0;
      end else if (tick) begin
        pre_q <= 4'h0;
        // 4*(limit+1) fine steps per period
        if (fine_q >= {period_limit_in, 2'h3}) begin
          fine_q <= 10'h000;
          period_start_q <= 1'b1;
        end else begin
          fine_q <= fine_q + 10'h001;
        end
      end else begin
        pre_q <= pre_q + 4'h1;
      end
    end
  end
endmodule // ewb_timebase

// ### logic/ewb_edge_delay.v
// Purpose: Defers the rising edge of a level by a programmed count
// Assumes: Falling edges pass with one register of latency
// Notes: Each count step is one instruction cycle of four clocks
`timescale 1ns/1ns
`include "ewb_regs.vh"
module ewb_edge_delay (
  input wire clock_in, // Oscillator clock
  input wire reset_in, // Async reset, active high
  input wire level_in, // Undelayed level
  input wire [6:0] delay_count_in, // Delay in instruction cycles
  output reg level_q // Delayed level
);
  reg [8:0] wait_q;

  // Rising edge waits count*4 clocks, falling edge is immediate
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      level_q <= 1'b0;
      wait_q <= 9'h000;
    end else if (!level_in) begin
      level_q <= 1'b0;
      wait_q <= {delay_count_in, 2'h0};
    end else if (!level_q) begin
      if (wait_q == 9'h000) begin
        level_q <= 1'b1;
      end else begin
        wait_q <= wait_q - 9'h001;
      end
    end
  end
endmodule // ewb_edge_delay

// ### logic/ewb_top.v
// Purpose: Enhanced PWM with single, half-bridge and full-bridge outputs
// Assumes: clock_in is the oscillator; registers reached over AXI4-Lite
// Notes: Shutdown pin is asynchronous and passes a three-stage synchroniser
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "ewb_regs.vh"
module ewb_top (
  input wire clock_in, // Oscillator clock, 10 MHz
  input wire reset_in, // Async reset, active high
  input wire shutdown_in, // Shutdown cause pin, active high
  input wire [4:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [4:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  output reg bridge_out_a_out, // Bridge output A
  output reg bridge_out_b_out, // Bridge output B
  output reg bridge_out_c_out, // Bridge output C
  output reg bridge_out_d_out // Bridge output D
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [7:0] period_limit_q;
  reg [7:0] duty_high_byte_q;
  reg [7:0] capture_compare_control_q;
  reg [7:0] pwm_restart_and_delay_control_q;
  reg [2:0] timer_control_q;
  reg [3:0] steer_q;
  reg shutdown_event_status_q;
  reg shutdown_event_status_d;
  reg [9:0] duty_act_q;
  reg mod_q;
  reg [2:0] sd_sync_q;
  reg sd_level_q;

  // Bus side holding registers
  reg aw_hold_q;
  reg [4:0] aw_addr_q;
  reg w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [31:0] rd_d;
  reg rd_err_d;
  reg wr_err_d;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire [1:0] bridge_mode_select;
  wire [9:0] duty_value;
  wire auto_restart_enable;
  wire [6:0] active_edge_delay_count;
  wire run;
  wire [9:0] fine;
  wire period_start;
  wire [10:0] period_steps;
  wire over_period;
  wire mod_dly;
  wire cmp_dly;
  wire wr_go;
  wire sw_clear;

  assign bridge_mode_select = capture_compare_control_q[`EWB_CC_MLSB +: 2];
  // Duty is high byte extended by two low bits
  assign duty_value = {duty_high_byte_q, capture_compare_control_q[`EWB_CC_DLSB +: 2]};
  assign auto_restart_enable = pwm_restart_and_delay_control_q[`EWB_RD_RSEN];
  assign active_edge_delay_count = pwm_restart_and_delay_control_q[6:0];
  assign run = timer_control_q[`EWB_TC_RUN];
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // ----------------------------------------
  // Timebase and edge delays
  // ----------------------------------------
  ewb_timebase u_tb (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .run_in(run),
    .prescale_sel_in(timer_control_q[1:0]),
    .period_limit_in(period_limit_q),
    .fine_q(fine),
    .period_start_q(period_start)
  );

  // Delay the modulated signal's active edge
  ewb_edge_delay u_dly_mod (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .level_in(mod_q),
    .delay_count_in(active_edge_delay_count),
    .level_q(mod_dly)
  );

  // Complement gets its own dead time so both never overlap
  ewb_edge_delay u_dly_cmp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .level_in(run && !mod_q),
    .delay_count_in(active_edge_delay_count),
    .level_q(cmp_dly)
  );

  // ----------------------------------------
  // Duty compare
  // ----------------------------------------
  // Period in fine steps; limit 255 gives 1024 steps, eleven bits
  assign period_steps = {1'b0, period_limit_q, 2'h3} + 11'h001;
  assign over_period = {1'b0, duty_act_q} > period_steps;

  // Duty takes effect at period start, avoiding a mid-period glitch
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      duty_act_q <= 10'h000;
      mod_q <= 1'b0;
    end else begin
      if (period_start || !run) begin
        duty_act_q <= duty_value;
      end
      if (!run) begin
        mod_q <= 1'b0;
      end else if (over_period) begin
        mod_q <= mod_q;
      end else begin
        mod_q <= fine < duty_act_q;
      end
    end
  end

  // ----------------------------------------
  // Shutdown input and status
  // ----------------------------------------
  // Third stage filters; a change counts when stages two and three agree
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sd_sync_q <= 3'h0;
      sd_level_q <= 1'b0;
    end else begin
      sd_sync_q <= {sd_sync_q[1:0], shutdown_in};
      if (sd_sync_q[1] == sd_sync_q[2]) begin
        sd_level_q <= sd_sync_q[2];
      end
    end
  end

  assign sw_clear = wr_go && (aw_addr_q == `EWB_OFS_STATUS) && w_strb_q[0] &&
    w_data_q[`EWB_ST_SES];

  // Set wins over any clear; auto clear only once the cause is gone
  always @* begin
    shutdown_event_status_d = shutdown_event_status_q;
    if (sd_level_q) begin
      shutdown_event_status_d = 1'b1;
    end else if (auto_restart_enable || sw_clear) begin
      shutdown_event_status_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Output steering
  // ----------------------------------------
  // Outputs inactive while stopped or shut down
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      bridge_out_a_out <= 1'b0;
      bridge_out_b_out <= 1'b0;
      bridge_out_c_out <= 1'b0;
      bridge_out_d_out <= 1'b0;
    end else if (shutdown_event_status_q || !run) begin
      bridge_out_a_out <= 1'b0;
      bridge_out_b_out <= 1'b0;
      bridge_out_c_out <= 1'b0;
      bridge_out_d_out <= 1'b0;
    end else begin
      case (bridge_mode_select)
        `EWB_MODE_SINGLE: begin
          bridge_out_a_out <= mod_dly && steer_q[0];
          bridge_out_b_out <= mod_dly && steer_q[1];
          bridge_out_c_out <= mod_dly && steer_q[2];
          bridge_out_d_out <= mod_dly && steer_q[3];
        end
        `EWB_MODE_HALF: begin
          bridge_out_a_out <= mod_dly;
          bridge_out_b_out <= cmp_dly;
          bridge_out_c_out <= 1'b0;
          bridge_out_d_out <= 1'b0;
        end
        `EWB_MODE_FWD: begin
          bridge_out_a_out <= 1'b1;
          bridge_out_b_out <= 1'b0;
          bridge_out_c_out <= 1'b0;
          bridge_out_d_out <= mod_dly;
        end
        default: begin
          bridge_out_a_out <= 1'b0;
          bridge_out_b_out <= mod_dly;
          bridge_out_c_out <= 1'b1;
          bridge_out_d_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  // Unmapped write addresses answer SLVERR and store nothing
  always @* begin
    case (aw_addr_q)
      `EWB_OFS_PERIOD, `EWB_OFS_DUTY, `EWB_OFS_CCCTL, `EWB_OFS_RSTDLY,
      `EWB_OFS_TMRCTL, `EWB_OFS_STEER, `EWB_OFS_STATUS: wr_err_d = 1'b0;
      default: wr_err_d = 1'b1;
    endcase
  end

  // Address and data are taken in either order; one write at a time
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EWB_RESP_OKAY;
      aw_hold_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err_d ? `EWB_RESP_SLVERR : `EWB_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register stores; only byte lane 0 carries data
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      period_limit_q <= `EWB_RST_PERIOD;
      duty_high_byte_q <= `EWB_RST_DUTY;
      capture_compare_control_q <= `EWB_RST_CCCTL;
      pwm_restart_and_delay_control_q <= `EWB_RST_RSTDLY;
      timer_control_q <= `EWB_RST_TMRCTL;
      steer_q <= `EWB_RST_STEER;
      shutdown_event_status_q <= 1'b0;
    end else begin
      shutdown_event_status_q <= shutdown_event_status_d;
      if (wr_go && w_strb_q[0]) begin
        case (aw_addr_q)
          `EWB_OFS_PERIOD: period_limit_q <= w_data_q[7:0];
          `EWB_OFS_DUTY: duty_high_byte_q <= w_data_q[7:0];
          `EWB_OFS_CCCTL: capture_compare_control_q <= w_data_q[7:0];
          `EWB_OFS_RSTDLY: pwm_restart_and_delay_control_q <= w_data_q[7:0];
          `EWB_OFS_TMRCTL: timer_control_q <= w_data_q[2:0];
          `EWB_OFS_STEER: steer_q <= w_data_q[3:0];
          default: period_limit_q <= period_limit_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  // Read mux; status shows live shutdown level and fine count
  always @* begin
    rd_d = 32'h0000_0000;
    rd_err_d = 1'b0;
    case (s_axi_araddr)
      `EWB_OFS_PERIOD: rd_d[7:0] = period_limit_q;
      `EWB_OFS_DUTY: rd_d[7:0] = duty_high_byte_q;
      `EWB_OFS_CCCTL: rd_d[7:0] = capture_compare_control_q;
      `EWB_OFS_RSTDLY: rd_d[7:0] = pwm_restart_and_delay_control_q;
      `EWB_OFS_TMRCTL: rd_d[2:0] = timer_control_q;
      `EWB_OFS_STEER: rd_d[3:0] = steer_q;
      `EWB_OFS_STATUS: begin
        rd_d[`EWB_ST_SES] = shutdown_event_status_q;
        rd_d[`EWB_ST_PIN] = sd_level_q;
        rd_d[`EWB_ST_CNT +: 10] = fine;
      end
      default: rd_err_d = 1'b1;
    endcase
  end

  // One read at a time; data is captured when the address is taken
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EWB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_err_d ? `EWB_RESP_SLVERR : `EWB_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ewb_top

// ### tb/ewb_top_asserts.sv
// Purpose: Port checks for the bridge PWM
// Assumes: Master offers write address and data together
// Notes: Mode and delay are shadowed from bus writes
`timescale 1ns/1ns
`include "ewb_regs.vh"
module ewb_top_asserts (
  input wire clock_in, // Clock
  input wire reset_in, // Reset
  input wire shutdown_in, // Fault pin
  input wire [4:0] s_axi_awaddr, // AW
  input wire s_axi_awvalid, // AW
  input wire s_axi_awready, // AW
  input wire [31:0] s_axi_wdata, // W
  input wire [3:0] s_axi_wstrb, // W
  input wire s_axi_wvalid, // W
  input wire s_axi_wready, // W
  input wire [1:0] s_axi_bresp, // B
  input wire s_axi_bvalid, // B
  input wire s_axi_bready, // B
  input wire [4:0] s_axi_araddr, // AR
  input wire s_axi_arvalid, // AR
  input wire s_axi_arready, // AR
  input wire [31:0] s_axi_rdata, // R
  input wire [1:0] s_axi_rresp, // R
  input wire s_axi_rvalid, // R
  input wire s_axi_rready, // R
  input wire bridge_out_a_out, // Pin A
  input wire bridge_out_b_out, // Pin B
  input wire bridge_out_c_out, // Pin C
  input wire bridge_out_d_out // Pin D
);
  // ----------------------------------------
  // Shadow of mode and delay
  // ----------------------------------------
  reg [1:0] mode_q;
  reg [6:0] dly_q;
  reg [3:0] calm_q;
  wire aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire calm = calm_q == 4'hF;
  // Pins lag a write by a few clocks, so pin checks wait until calm
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode_q <= 2'h0;
      dly_q <= 7'h00;
      calm_q <= 4'h0;
    end else if (aw_go) begin
      calm_q <= 4'h0;
      if (s_axi_wstrb[0] && s_axi_awaddr == `EWB_OFS_CCCTL) mode_q <= s_axi_wdata[7:6];
      if (s_axi_wstrb[0] && s_axi_awaddr == `EWB_OFS_RSTDLY) dly_q <= s_axi_wdata[6:0];
    end else if (!calm) begin
      calm_q <= calm_q + 4'h1;
    end
  end
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  a_write_resp: assert property (aw_go && s_axi_awaddr[1:0] == 2'h0 |-> ##2 s_axi_bvalid &&
    s_axi_bresp == ($past(s_axi_awaddr, 2) > 5'h18 ? `EWB_RESP_SLVERR : `EWB_RESP_OKAY))
    else $error("write response wrong");
  a_read_resp: assert property (ar_go && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rvalid &&
    s_axi_rresp == ($past(s_axi_araddr) > 5'h18 ? `EWB_RESP_SLVERR : `EWB_RESP_OKAY))
    else $error("read response wrong");
  a_read_zero: assert property (ar_go && s_axi_araddr > 5'h18 |=> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped");
  a_data_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
  a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken early");
  a_half_pins: assert property (
    calm && mode_q == `EWB_MODE_HALF |-> !bridge_out_c_out && !bridge_out_d_out)
    else $error("half mode drives C or D");
  a_fwd_pins: assert property (
    calm && mode_q == `EWB_MODE_FWD |-> !bridge_out_b_out && !bridge_out_c_out)
    else $error("forward mode drives B or C");
  a_rev_pins: assert property (
    calm && mode_q == `EWB_MODE_REV |-> !bridge_out_a_out && !bridge_out_d_out)
    else $error("reverse mode drives A or D");
  a_half_gap: assert property (
    calm && mode_q == `EWB_MODE_HALF && dly_q != 7'h00 |-> !(bridge_out_a_out && bridge_out_b_out))
    else $error("half bridge overlap");
  a_shutdown_off: assert property (shutdown_in [*8] |=> !(bridge_out_a_out ||
    bridge_out_b_out || bridge_out_c_out || bridge_out_d_out)) else $error("pins on in shutdown");
  cover property (calm && mode_q == `EWB_MODE_HALF && bridge_out_b_out);
  cover property (calm && mode_q == `EWB_MODE_FWD && bridge_out_d_out);
  cover property (shutdown_in [*8]);
endmodule // ewb_top_asserts
bind ewb_top ewb_top_asserts chk_u (.clock_in, .reset_in, .shutdown_in, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bridge_out_a_out,
  .bridge_out_b_out, .bridge_out_c_out, .bridge_out_d_out);

// ### tb/ewb_bridge_model.sv
// Purpose: Bridge driver stage that reports overcurrent
// Assumes: Legs pair A with B and C with D
// Notes: Fault report lags the request by a set count
`timescale 1ns/1ns
module ewb_bridge_model (
  input wire clock_in, // Clock
  input wire leg_a_in, // Pin A
  input wire leg_b_in, // Pin B
  input wire leg_c_in, // Pin C
  input wire leg_d_in, // Pin D
  input wire fault_req_in, // Bench fault
  input wire [1:0] fault_lat_in, // Report lag
  output reg shutdown_out = 1'h0, // Fault line
  output reg [15:0] short_cnt_out = 16'h0000 // Shorted cycles
);
  // ----------------------------------------
  // Fault line and leg watch
  // ----------------------------------------
  reg [1:0] lag_q = 2'h0;
  // Line held low when healthy; the cause stays until the bench lifts it
  always @(posedge clock_in) begin
    if (!fault_req_in) begin
      shutdown_out <= 1'h0;
      lag_q <= fault_lat_in;
    end else if (lag_q == 2'h0) begin
      shutdown_out <= 1'h1;
    end else begin
      lag_q <= lag_q - 2'h1;
    end
    // Both switches of one leg on would short the supply
    if ((leg_a_in && leg_b_in) || (leg_c_in && leg_d_in)) short_cnt_out <= short_cnt_out + 16'h0001;
  end
endmodule // ewb_bridge_model

// ### tb/ewb_top_tb.sv
// Purpose: Self-checking bench for the bridge PWM
// Assumes: 10 MHz clock, bridge model on the fault pin
// Notes: High time is counted over four whole periods at any phase
`timescale 1ns/1ns
`include "ewb_regs.vh"
module ewb_top_tb;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  reg clock_in = 1'h0;
  reg reset_in = 1'h1;
  reg [4:0] s_axi_awaddr = 5'h00;
  reg s_axi_awvalid = 1'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_wvalid = 1'h0;
  reg s_axi_bready = 1'h0;
  reg [4:0] s_axi_araddr = 5'h00;
  reg s_axi_arvalid = 1'h0;
  reg s_axi_rready = 1'h0;
  reg fault_req = 1'h0;
  reg [1:0] fault_lat = 2'h0;
  wire shutdown_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire bridge_out_a_out, bridge_out_b_out, bridge_out_c_out, bridge_out_d_out;
  wire [15:0] short_cnt;
  wire [3:0] outs = {bridge_out_d_out, bridge_out_c_out, bridge_out_b_out, bridge_out_a_out};
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int per;
  int hi[4];
  reg [31:0] v;
  reg [1:0] r;
  reg [7:0] lim;
  reg [9:0] dut;
  // Per pin: 0 off, 1 on, 2 delayed pulse, 3 delayed complement
  reg [7:0] cd [7] = '{8'h0E, 8'h81, 8'h18, 8'h02, 8'h08, 8'h20, 8'h80};
  reg [1:0] md [7] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
  reg [3:0] st [7] = '{4'hF, 4'hF, 4'hF, 4'h1, 4'h2, 4'h4, 4'h8};
  reg [7:0] rstv [6] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  // Clock and parts
  always #50 clock_in = ~clock_in;
  ewb_top dut_u (.clock_in, .reset_in, .shutdown_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bridge_out_a_out, .bridge_out_b_out,
    .bridge_out_c_out, .bridge_out_d_out);
  ewb_bridge_model mdl_u (.clock_in, .leg_a_in(bridge_out_a_out), .leg_b_in(bridge_out_b_out),
    .leg_c_in(bridge_out_c_out), .leg_d_in(bridge_out_d_out), .fault_req_in(fault_req),
    .fault_lat_in(fault_lat), .shutdown_out(shutdown_in), .short_cnt_out(short_cnt));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d, compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Address and data leave each on its own ready; a hang ends at the watchdog
  task automatic wr(input [4:0] a, input [31:0] d, input [3:0] s, output [1:0] rs);
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clock_in); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h1;
    @(posedge clock_in);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input [4:0] a, output [31:0] d, output [1:0] rs);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clock_in); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock_in); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge clock_in);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic win(input int n);
    hi = '{0, 0, 0, 0};
    repeat (n) begin
      @(posedge clock_in);
      for (int i = 0; i < 4; i++) hi[i] += int'(outs[i] === 1'h1);
    end
  endtask
  function automatic int pf(input [1:0] s);
    return s == 2'h0 ? 1 : (s == 2'h1 ? 4 : 16);
  endfunction
  // Duty 20 and delay 2 (8 clocks) in the mode table
  function automatic int ex(input [1:0] c);
    if (c == 2'h0) return 0;
    if (c == 2'h1) return 4 * per;
    if (c == 2'h2) return 4 * (20 - 8);
    return 4 * (per - 20 - 8);
  endfunction
  // Timer is stopped while set up, so pins sit low during mode changes
  task automatic cfg(input [1:0] m, input [7:0] l, input [1:0] ps, input [9:0] d,
                     input [7:0] dl, input [3:0] s);
    wr(`EWB_OFS_TMRCTL, 32'h0, 4'hF, r);
    wr(`EWB_OFS_PERIOD, 32'(l), 4'hF, r);
    wr(`EWB_OFS_DUTY, 32'(d[9:2]), 4'hF, r);
    wr(`EWB_OFS_CCCTL, 32'({m, d[1:0], 4'h0}), 4'hF, r);
    wr(`EWB_OFS_RSTDLY, 32'(dl), 4'hF, r);
    wr(`EWB_OFS_STEER, 32'(s), 4'hF, r);
    wr(`EWB_OFS_TMRCTL, 32'({1'h1, ps}), 4'hF, r);
    per = 4 * (l + 1) * pf(ps);
    repeat (2 * per + 40) @(posedge clock_in);
  endtask
  // Watchdog
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      close_out;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    v = $urandom(82);
    repeat (12) @(posedge clock_in);
    reset_in <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      rd(5'(4 * i), v, r);
      chk(v, 32'(rstv[i]));
    end
    rd(5'h1C, v, r);
    chk(v, 32'h0);
    chk(32'(r), 32'(`EWB_RESP_SLVERR));
    wr(5'h1C, 32'h1, 4'hF, r);
    chk(32'(r), 32'(`EWB_RESP_SLVERR));
    lim = 8'($urandom);
    wr(`EWB_OFS_RSTDLY, 32'(lim), 4'h0, r);
    rd(`EWB_OFS_RSTDLY, v, r);
    chk(v, 32'h0);
    wr(`EWB_OFS_RSTDLY, 32'(lim), 4'hF, r);
    rd(`EWB_OFS_RSTDLY, v, r);
    chk(v, 32'(lim));
    // Every prescale choice with random limit and duty, then the full-range corner
    for (int s = 0; s < 6; s++) begin
      lim = s < 4 ? 8'($urandom_range(15, 3)) : 8'hFF;
      dut = s < 4 ? 10'($urandom_range(4 * lim + 3, 1)) : (s == 4 ? 10'h001 : 10'h3FF);
      cfg(2'h0, lim, 2'(s & 3), dut, 8'h00, 4'h1);
      win(4 * per);
      chk(32'(hi[0]), 32'(4 * dut * pf(2'(s & 3))));
    end
    // Duty beyond the period end
    cfg(2'h0, 8'h07, 2'h0, 10'h00C, 8'h00, 4'h1);
    wr(`EWB_OFS_DUTY, 32'h0A, 4'hF, r);
    repeat (2 * per) @(posedge clock_in);
    win(4 * per);
    chk(32'(hi[0] == 0 || hi[0] == 4 * per), 32'h1);
    // Each mode, and single mode steered to each one pin, with a delayed active edge
    for (int k = 0; k < 7; k++) begin
      cfg(md[k], 8'h07, 2'h0, 10'h014, 8'h02, st[k]);
      win(4 * per);
      for (int j = 0; j < 4; j++) chk(32'(hi[j]), 32'(ex(cd[k][2*j +: 2])));
    end
    // Shutdown with software and with automatic restart
    for (int rs = 0; rs < 2; rs++) begin
      cfg(2'h0, 8'h07, 2'h0, 10'h00C, {rs[0], 7'h00}, 4'h1);
      fault_lat <= 2'($urandom_range(3, 0));
      fault_req <= 1'h1;
      repeat (20) @(posedge clock_in);
      rd(`EWB_OFS_STATUS, v, r);
      chk(32'(v[0]), 32'h1);
      fault_req <= 1'h0;
      repeat (2 * per) @(posedge clock_in);
      rd(`EWB_OFS_STATUS, v, r);
      chk(32'(v[0]), 32'(rs == 0));
      win(4 * per);
      chk(32'(hi[0]), 32'(rs * 48));
      wr(`EWB_OFS_STATUS, 32'h1, 4'hF, r);
      repeat (2 * per) @(posedge clock_in);
      win(4 * per);
      chk(32'(hi[0]), 32'(48));
    end
    chk(32'(short_cnt), 32'h0);
    close_out;
  end
endmodule // ewb_top_tb
